/* File: rtl/ubg_pkg.sv */
// Constants, widths and mode types of the unbalance and ground trip logic
// Notes on behaviour
// R1 - ground reset: characteristic, delayed or instant
// R2 - characteristic reset delay is five times multiplier
// R3 - supervise-only setting suppresses the ground trip
// R4 - ground pickup scaled by earth transformer primary
// R5 - sequence currents honour the phase rotation
// R6 - unbalance ratio is negative over positive percent
// R7 - unbalance trip: threshold, optional ratio, delay
// R8 - negative threshold in multiples of rated current
// R9 - fixed curve counts the configured delay
// R10 - thermal curve derives its own delay
// R11 - thermal energy is updated at all times; the code updates it only on a sample tick with enable high
// R12 - thermal trip also needs energy above maximum
// R13 - cold delay is capacity over excess square
// R14 - heating integrates squared negative current
// R15 - cooling decays energy with time constant
// R16 - energy under one hundredth of maximum clears
// R17 - timers advance on tick, clear on reset
package ubg_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int I_W      = 12;          // Phasor component and current inputs
  localparam int SET_W    = 8;           // Thresholds, fixed point with THR_FRAC
  localparam int PROD_W   = SET_W + I_W; // Threshold times base current
  localparam int PCT_W    = 7;           // Ratio pickup in percent
  localparam int T_W      = 16;          // Delay settings in ticks
  localparam int RST_W    = T_W + 3;     // Reset delay after multiplication
  localparam int SQ_W     = 48;          // Squared magnitudes and energy
  localparam int C_W      = 16;          // Rotated phasor components
  localparam int P_W      = 30;          // Products inside the rotation
  localparam int SHIFT_W  = 5;           // Cooling time constant as a shift
  localparam int THR_FRAC = 4;           // Fraction bits of thresholds

  // ****************************************
  // Scaling and timing constants
  // ****************************************
  localparam logic [15:0]      SQRT3_HALF_Q14  = 16'h376d; // sqrt(3)/2 in Q14
  localparam int               Q_SHIFT         = 14;
  localparam logic [1:0]       SEQ_SCALE       = 2'h3;     // Sums are 3x sequence
  localparam logic [13:0]      PCT_SCALE_SQ    = 14'h2710; // 100 squared
  localparam logic [6:0]       COOL_FLOOR_DIV  = 7'h64;    // Floor is max/100
  localparam logic [2:0]       CHAR_RESET_MULT = 3'h5;     // Reset is 5x multiplier

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [SQ_W-1:0]  THETA_RST = 48'h0;
  localparam logic [T_W-1:0]   T_RST     = 16'h0;
  localparam logic [RST_W-1:0] RC_RST    = 19'h0;

  // ****************************************
  // Mode types
  // ****************************************
  typedef enum logic {fixed_delay_curve, thermal_dependent_curve} ubg_curve_t;
  typedef enum logic [1:0] {rst_characteristic, rst_delayed, rst_instant} ubg_rst_mode_t;
  typedef enum logic [1:0] {gnd_idle, gnd_timing, gnd_resetting} ubg_gnd_state_t;
endpackage

/* File: rtl/ubg_seq.sv */
// Positive and negative sequence magnitudes from three phase phasors
`timescale 1ns/1ps
`default_nettype none
module ubg_seq (
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic                              ce,
  input  wire logic signed [ubg_pkg::I_W-1:0]    ia_re,
  input  wire logic signed [ubg_pkg::I_W-1:0]    ia_im,
  input  wire logic signed [ubg_pkg::I_W-1:0]    ib_re,
  input  wire logic signed [ubg_pkg::I_W-1:0]    ib_im,
  input  wire logic signed [ubg_pkg::I_W-1:0]    ic_re,
  input  wire logic signed [ubg_pkg::I_W-1:0]    ic_im,
  input  wire logic                              phase_reversed,
  output logic             [ubg_pkg::SQ_W-1:0]   pos_sq,
  output logic             [ubg_pkg::SQ_W-1:0]   neg_sq
);
  import ubg_pkg::*;

  typedef struct packed {
    logic [SQ_W-1:0] pos_sq;
    logic [SQ_W-1:0] neg_sq;
  } ubg_seq_st_t;

  ubg_seq_st_t             st;
  ubg_seq_st_t             next_st;
  logic signed [I_W-1:0]   b_re;
  logic signed [I_W-1:0]   b_im;
  logic signed [I_W-1:0]   c_re;
  logic signed [I_W-1:0]   c_im;
  logic signed [C_W-1:0]   ab_re, ab_im, a2b_re, a2b_im;
  logic signed [C_W-1:0]   ac_re, ac_im, a2c_re, a2c_im;
  logic signed [C_W-1:0]   p_re, p_im, n_re, n_im;

  // Rotate by a (fwd) or by a squared; fixed point keeps it multiplier-light
  function automatic logic [2*C_W-1:0] ubg_rot(input logic signed [I_W-1:0] re,
                                               input logic signed [I_W-1:0] im,
                                               input logic fwd);
    logic signed [P_W-1:0] kre;
    logic signed [P_W-1:0] kim;
    logic signed [C_W-1:0] hre;
    logic signed [C_W-1:0] him;
    logic signed [C_W-1:0] ore;
    logic signed [C_W-1:0] oim;
    kre = (P_W'(re) * $signed(P_W'(SQRT3_HALF_Q14))) >>> Q_SHIFT;
    kim = (P_W'(im) * $signed(P_W'(SQRT3_HALF_Q14))) >>> Q_SHIFT;
    hre = C_W'(re >>> 1);
    him = C_W'(im >>> 1);
    ore = fwd ? (-hre - C_W'(kim)) : (-hre + C_W'(kim));
    oim = fwd ? (C_W'(kre) - him) : (-C_W'(kre) - him);
    return {ore, oim};
  endfunction

  // R5 rotation order swaps B and C
  assign b_re = phase_reversed ? ic_re : ib_re;
  assign b_im = phase_reversed ? ic_im : ib_im;
  assign c_re = phase_reversed ? ib_re : ic_re;
  assign c_im = phase_reversed ? ib_im : ic_im;
  assign {ab_re, ab_im}   = ubg_rot(b_re, b_im, 1'b1);
  assign {a2b_re, a2b_im} = ubg_rot(b_re, b_im, 1'b0);
  assign {ac_re, ac_im}   = ubg_rot(c_re, c_im, 1'b1);
  assign {a2c_re, a2c_im} = ubg_rot(c_re, c_im, 1'b0);

  // R5 three times the sequence phasors, no divide
  assign p_re = C_W'(ia_re) + ab_re + a2c_re;
  assign p_im = C_W'(ia_im) + ab_im + a2c_im;
  assign n_re = C_W'(ia_re) + a2b_re + ac_re;
  assign n_im = C_W'(ia_im) + a2b_im + ac_im;

  // Squared magnitudes; comparisons downstream avoid a square root
  always_comb begin
    next_st        = st;
    next_st.pos_sq = SQ_W'(p_re) * SQ_W'(p_re) + SQ_W'(p_im) * SQ_W'(p_im);
    next_st.neg_sq = SQ_W'(n_re) * SQ_W'(n_re) + SQ_W'(n_im) * SQ_W'(n_im);
  end

  // Registered once per enabled cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{pos_sq: THETA_RST, neg_sq: THETA_RST};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pos_sq = st.pos_sq;
  assign neg_sq = st.neg_sq;
endmodule
`default_nettype wire

/* File: rtl/ubg_top.sv */
// Unbalance and ground overcurrent trip decisions of a motor relay
`timescale 1ns/1ps
`default_nettype none
module ubg_top (
  input  wire logic                                 clk,
  input  wire logic                                 arst_n,
  input  wire logic                                 ce,
  input  wire logic                                 sample_tick,
  input  wire logic signed [ubg_pkg::I_W-1:0]       ia_re,
  input  wire logic signed [ubg_pkg::I_W-1:0]       ia_im,
  input  wire logic signed [ubg_pkg::I_W-1:0]       ib_re,
  input  wire logic signed [ubg_pkg::I_W-1:0]       ib_im,
  input  wire logic signed [ubg_pkg::I_W-1:0]       ic_re,
  input  wire logic signed [ubg_pkg::I_W-1:0]       ic_im,
  input  wire logic                                 phase_reversed,
  input  wire logic        [ubg_pkg::I_W-1:0]       rated_current,
  input  wire logic        [ubg_pkg::SET_W-1:0]     negative_sequence_threshold,
  input  wire logic                                 ratio_enable,
  input  wire logic        [ubg_pkg::PCT_W-1:0]     unbalance_ratio_pickup,
  input  wire ubg_pkg::ubg_curve_t                  unb_curve,
  input  wire logic        [ubg_pkg::T_W-1:0]       unb_delay,
  input  wire logic        [ubg_pkg::T_W-1:0]       thermal_capacity,
  input  wire logic        [ubg_pkg::SHIFT_W-1:0]   cool_shift,
  input  wire logic        [ubg_pkg::I_W-1:0]       ground_current,
  input  wire logic        [ubg_pkg::SET_W-1:0]     ground_pickup_threshold,
  input  wire logic        [ubg_pkg::I_W-1:0]       earth_ct_primary,
  input  wire logic                                 gnd_supervise_only,
  input  wire logic                                 gnd_block,
  input  wire logic        [ubg_pkg::T_W-1:0]       gnd_trip_delay,
  input  wire ubg_pkg::ubg_rst_mode_t               gnd_reset_mode,
  input  wire logic        [ubg_pkg::T_W-1:0]       gnd_time_mult,
  input  wire logic        [ubg_pkg::T_W-1:0]       gnd_reset_delay,
  output logic                                      unb_alarm,
  output logic                                      unb_trip,
  output logic                                      gnd_alarm,
  output logic                                      gnd_trip
);
  import ubg_pkg::*;

  // ****************************************
  // State and working signals
  // ****************************************
  typedef struct packed {
    logic [SQ_W-1:0]  theta;
    logic [T_W-1:0]   unb_cnt;
    logic [T_W-1:0]   gnd_cnt;
    logic [RST_W-1:0] gnd_rst_cnt;
    ubg_gnd_state_t   gs;
    logic             unb_alarm;
    logic             unb_trip;
    logic             gnd_alarm;
    logic             gnd_trip;
  } ubg_main_st_t;

  localparam ubg_main_st_t ST_RST = '{theta: THETA_RST, unb_cnt: T_RST,
                                      gnd_cnt: T_RST, gnd_rst_cnt: RC_RST,
                                      gs: gnd_idle, unb_alarm: 1'b0,
                                      unb_trip: 1'b0, gnd_alarm: 1'b0,
                                      gnd_trip: 1'b0};

  ubg_main_st_t       st;
  ubg_main_st_t       next_st;
  logic [SQ_W-1:0]    pos_sq;
  logic [SQ_W-1:0]    neg_sq;
  logic [PROD_W-1:0]  thr_prod;
  logic [SQ_W-1:0]    thr3;
  logic [SQ_W-1:0]    thr_sq;
  logic [SQ_W-1:0]    in3;
  logic [SQ_W-1:0]    theta_max;
  logic [SQ_W-1:0]    cool_floor;
  logic [SQ_W:0]      heat_sum;
  logic [SQ_W-1:0]    cooled;
  logic               neg_over;
  logic               ratio_ok;
  logic               unb_cond;
  logic [PROD_W-1:0]  gnd_prod;
  logic               gnd_pick;
  logic [RST_W-1:0]   rst_target;

  // Sequence magnitudes, one cycle of latency
  ubg_seq u_seq (
    .clk            (clk),
    .arst_n         (arst_n),
    .ce             (ce),
    .ia_re          (ia_re),
    .ia_im          (ia_im),
    .ib_re          (ib_re),
    .ib_im          (ib_im),
    .ic_re          (ic_re),
    .ic_im          (ic_im),
    .phase_reversed (phase_reversed),
    .pos_sq         (pos_sq),
    .neg_sq         (neg_sq)
  );

  // ****************************************
  // Unbalance decision
  // ****************************************
  // R8 threshold is a multiple of rated current
  assign thr_prod = PROD_W'(negative_sequence_threshold) * PROD_W'(rated_current);
  // Scaled by three to match the undivided sequence sums
  assign thr3     = SQ_W'(thr_prod[PROD_W-1:THR_FRAC]) * SQ_W'(SEQ_SCALE);
  assign thr_sq   = thr3 * thr3;
  assign in3      = SQ_W'(rated_current) * SQ_W'(SEQ_SCALE);
  // R12 maximum energy from the capacity setting
  assign theta_max  = SQ_W'(thermal_capacity) * in3 * in3;
  assign cool_floor = theta_max / SQ_W'(COOL_FLOOR_DIV);
  assign neg_over   = neg_sq > thr_sq;
  // R6 percent ratio compared in squares
  assign ratio_ok = !ratio_enable ||
                    (SQ_W'(PCT_SCALE_SQ) * neg_sq >
                     SQ_W'(unbalance_ratio_pickup) * SQ_W'(unbalance_ratio_pickup) * pos_sq);
  // R7 threshold and optional ratio
  assign unb_cond = neg_over && ratio_ok;
  // R14 R13 excess over threshold, so cold delay is K*In^2/(I2^2-thr^2)
  assign heat_sum = {1'b0, st.theta} + {1'b0, neg_sq - thr_sq};
  // R15 one exponential step; time constant is 2^cool_shift ticks
  assign cooled   = st.theta - (st.theta >> cool_shift);

  // ****************************************
  // Ground decision
  // ****************************************
  // R4 pickup scaled by earth transformer primary
  assign gnd_prod = PROD_W'(ground_pickup_threshold) * PROD_W'(earth_ct_primary);
  assign gnd_pick = T_W'(ground_current) > gnd_prod[PROD_W-1:THR_FRAC];
  // R2 R1 characteristic or fixed reset delay
  assign rst_target = (gnd_reset_mode == rst_characteristic) ?
                      RST_W'(CHAR_RESET_MULT) * RST_W'(gnd_time_mult) :
                      RST_W'(gnd_reset_delay);

  // Next state of the whole block
  always_comb begin
    next_st           = st;
    next_st.unb_alarm = unb_cond;
    next_st.gnd_alarm = gnd_pick;
    // R17 timers count and energy moves only on the tick
    if (sample_tick) begin
      // R11 energy tracked whatever the curve or trip
      if (neg_over) begin
        next_st.theta = heat_sum[SQ_W] ? {SQ_W{1'b1}} : heat_sum[SQ_W-1:0];
      end else begin
        // R16 small residue cleared to zero
        next_st.theta = (cooled < cool_floor) ? THETA_RST : cooled;
      end
      if (unb_cond && st.unb_cnt != {T_W{1'b1}}) begin
        next_st.unb_cnt = st.unb_cnt + 1'b1;
      end
    end
    // R9 delay must be continuous, so it restarts on any gap
    if (!unb_cond) begin
      next_st.unb_cnt = T_RST;
    end
    // R10 R12 thermal mode trips on energy instead of a setting
    if (unb_curve == fixed_delay_curve) begin
      next_st.unb_trip = unb_cond && (st.unb_cnt >= unb_delay);
    end else begin
      next_st.unb_trip = unb_cond && (st.theta >= theta_max);
    end
    // R1 ground timer and its reset behaviour
    case (st.gs)
      gnd_idle: begin
        next_st.gnd_rst_cnt = RC_RST;
        if (gnd_pick) begin
          next_st.gs = gnd_timing;
        end
      end
      gnd_timing: begin
        if (!gnd_pick) begin
          if (gnd_reset_mode == rst_instant) begin
            next_st.gnd_cnt = T_RST;
            next_st.gs      = gnd_idle;
          end else begin
            next_st.gnd_rst_cnt = RC_RST;
            next_st.gs          = gnd_resetting;
          end
        end else if (sample_tick && st.gnd_cnt != {T_W{1'b1}}) begin
          next_st.gnd_cnt = st.gnd_cnt + 1'b1;
        end
      end
      gnd_resetting: begin
        // Timer held, so a brief dip does not lose progress
        if (gnd_pick) begin
          next_st.gs = gnd_timing;
        end else if (st.gnd_rst_cnt >= rst_target) begin
          next_st.gnd_cnt = T_RST;
          next_st.gs      = gnd_idle;
        end else if (sample_tick) begin
          next_st.gnd_rst_cnt = st.gnd_rst_cnt + 1'b1;
        end
      end
      default: begin
        next_st.gs = gnd_idle;
      end
    endcase
    // R3 trip only when not supervising, and not blocked
    next_st.gnd_trip = gnd_pick && (st.gs == gnd_timing) &&
                       (st.gnd_cnt >= gnd_trip_delay) &&
                       !gnd_supervise_only && !gnd_block;
  end

  // R17 everything clears on reset; low enable freezes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign unb_alarm = st.unb_alarm;
  assign unb_trip  = st.unb_trip;
  assign gnd_alarm = st.gnd_alarm;
  assign gnd_trip  = st.gnd_trip;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_gnd_superv;
    ce && (gnd_supervise_only || gnd_block) |=> !gnd_trip;
  endproperty
  a_gnd_superv: assert property (p_gnd_superv) // R3
    else $error("ground trip while supervising or blocked");

  property p_gnd_instant;
    ce && st.gs == gnd_timing && !gnd_pick && gnd_reset_mode == rst_instant
      |=> st.gs == gnd_idle && st.gnd_cnt == T_RST;
  endproperty
  a_gnd_instant: assert property (p_gnd_instant) // R1
    else $error("instant reset did not clear ground timer");

  property p_gnd_char;
    ce && st.gs == gnd_resetting && !gnd_pick && gnd_reset_mode == rst_characteristic
      && st.gnd_rst_cnt < RST_W'(CHAR_RESET_MULT) * RST_W'(gnd_time_mult)
      |=> st.gnd_cnt == $past(st.gnd_cnt);
  endproperty
  a_gnd_char: assert property (p_gnd_char) // R2
    else $error("ground timer cleared before reset delay");

  property p_gnd_scale;
    ce && T_W'(ground_current) <= gnd_prod[PROD_W-1:THR_FRAC] |=> !gnd_alarm ##0 !gnd_trip;
  endproperty
  a_gnd_scale: assert property (p_gnd_scale) // R4
    else $error("ground alarm below scaled pickup");

  property p_unb_drop;
    ce && !unb_cond |=> !unb_trip && !unb_alarm;
  endproperty
  a_unb_drop: assert property (p_unb_drop) // R7
    else $error("unbalance output without condition");

  property p_unb_def;
    ce && unb_curve == fixed_delay_curve && st.unb_cnt < unb_delay |=> !unb_trip;
  endproperty
  a_unb_def: assert property (p_unb_def) // R9
    else $error("fixed curve trip before delay");

  property p_unb_therm;
    ce && unb_curve == thermal_dependent_curve && st.theta < theta_max |=> !unb_trip;
  endproperty
  a_unb_therm: assert property (p_unb_therm) // R12
    else $error("thermal trip below maximum energy");

  property p_heat;
    ce && sample_tick && neg_over |=> st.theta >= $past(st.theta);
  endproperty
  a_heat: assert property (p_heat) // R14
    else $error("energy fell while heating");

  property p_cool;
    ce && sample_tick && !neg_over |=> st.theta <= $past(st.theta)
      && (st.theta == THETA_RST || st.theta >= $past(cool_floor));
  endproperty
  a_cool: assert property (p_cool) // R16
    else $error("cooling rose or left residue");

  property p_tick;
    ce && !sample_tick |=> st.theta == $past(st.theta) && st.gnd_cnt <= $past(st.gnd_cnt);
  endproperty
  a_tick: assert property (p_tick) // R17
    else $error("energy moved without tick");

  c_gnd_trip:  cover property (ce ##1 $rose(gnd_trip));
  c_unb_fixed: cover property (unb_curve == fixed_delay_curve ##1 $rose(unb_trip));
  c_unb_therm: cover property (unb_curve == thermal_dependent_curve ##1 $rose(unb_trip));
  c_cool_zero: cover property (st.theta != THETA_RST ##1 st.theta == THETA_RST);
endmodule
`default_nettype wire

/* File: sim/ubg_top_tb.sv */
// Self-checking bench for the unbalance and ground trip logic
`timescale 1ns/1ps
`default_nettype none
module ubg_top_tb;
  import ubg_pkg::*;
  logic                    clk, arst_n, ce, phase_reversed;
  logic                    sample_tick = 1'b0;
  logic signed [I_W-1:0]   ia_re, ia_im, ib_re, ib_im, ic_re, ic_im;
  logic        [I_W-1:0]   rated_current, ground_current, earth_ct_primary;
  logic        [SET_W-1:0] negative_sequence_threshold, ground_pickup_threshold;
  logic        [PCT_W-1:0] unbalance_ratio_pickup;
  logic        [T_W-1:0]   unb_delay, thermal_capacity, gnd_trip_delay;
  logic        [T_W-1:0]   gnd_time_mult, gnd_reset_delay;
  logic      [SHIFT_W-1:0] cool_shift;
  logic                    ratio_enable, gnd_supervise_only, gnd_block;
  logic                    unb_alarm, unb_trip, gnd_alarm, gnd_trip;
  ubg_curve_t              unb_curve;
  ubg_rst_mode_t           gnd_reset_mode;
  int                      fails, n_checks, n;

  ubg_top dut (
    .clk(clk), .arst_n(arst_n), .ce(ce), .sample_tick(sample_tick),
    .ia_re(ia_re), .ia_im(ia_im), .ib_re(ib_re), .ib_im(ib_im), .ic_re(ic_re), .ic_im(ic_im),
    .phase_reversed(phase_reversed), .rated_current(rated_current),
    .negative_sequence_threshold(negative_sequence_threshold), .ratio_enable(ratio_enable),
    .unbalance_ratio_pickup(unbalance_ratio_pickup), .unb_curve(unb_curve),
    .unb_delay(unb_delay), .thermal_capacity(thermal_capacity), .cool_shift(cool_shift),
    .ground_current(ground_current), .ground_pickup_threshold(ground_pickup_threshold),
    .earth_ct_primary(earth_ct_primary), .gnd_supervise_only(gnd_supervise_only),
    .gnd_block(gnd_block), .gnd_trip_delay(gnd_trip_delay), .gnd_reset_mode(gnd_reset_mode),
    .gnd_time_mult(gnd_time_mult), .gnd_reset_delay(gnd_reset_delay),
    .unb_alarm(unb_alarm), .unb_trip(unb_trip), .gnd_alarm(gnd_alarm), .gnd_trip(gnd_trip)
  );

  // ****************************************
  // Clock, tick and helpers
  // ****************************************
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // One tick every second cycle, so ticks and cycles can be told apart
  // Free running through reset, so its phase never races the stimulus
  always @(negedge clk) begin
    sample_tick <= ~sample_tick;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi, input string msg);
    n_checks++;
    if (v < lo || v > hi) begin
      fails++;
      $display("unexpected at %0t: %s took %0d cycles", $time, msg, v);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return unb_alarm;
      1: return unb_trip;
      2: return gnd_alarm;
      default: return gnd_trip;
    endcase
  endfunction

  // Bounded wait for an output to rise; count of cycles returned
  task automatic wait_out(input int sel, input int lim, output int k);
    k = 0;
    while (pick(sel) !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic phase(input int ar, input int ai, input int br, input int bi,
                       input int cr, input int ci);
    ia_re = I_W'(ar);
    ia_im = I_W'(ai);
    ib_re = I_W'(br);
    ib_im = I_W'(bi);
    ic_re = I_W'(cr);
    ic_im = I_W'(ci);
  endtask

  // Drop the ground current for gap ticks, then see if timing resumed
  task automatic gnd_gap(input ubg_rst_mode_t m, input int gap, input logic fast);
    int k;
    gnd_reset_mode = m;
    wait_out(3, 40, k);
    ground_current = 12'h000;
    cyc(2 * gap);
    chk(gnd_trip, 1'b0, "ground trip held while resetting");
    ground_current = 12'h191;
    wait_out(3, 40, k);
    chk((k <= 5) ? 1'b1 : 1'b0, fast, "ground timing resume after gap");
  endtask

  // Cool for gap ticks with the given shift, then heat again
  task automatic heat_run(input int gap, input logic [SHIFT_W-1:0] sh, input int lo,
                          input int hi);
    int k;
    cool_shift = sh;
    phase(0, 0, 0, 0, 0, 0);
    cyc(2 * gap);
    chk(unb_trip, 1'b0, "thermal trip drops while cooling");
    phase(1500, 0, 0, 0, 0, 0);
    wait_out(1, 400, k);
    chk_rng(k, lo, hi, "thermal trip");
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog well past the roughly 800 cycles the tests need
  initial begin
    #(50 * 20000);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    fails = 0;
    n_checks = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    phase(0, 0, 0, 0, 0, 0);
    phase_reversed = 1'b0;
    rated_current = 12'h1e0;
    negative_sequence_threshold = 8'h10;
    ratio_enable = 1'b0;
    unbalance_ratio_pickup = 7'h00;
    unb_curve = fixed_delay_curve;
    unb_delay = 16'h0014;
    thermal_capacity = 16'h000a;
    cool_shift = 5'h0a;
    ground_current = 12'h000;
    ground_pickup_threshold = 8'h08;
    earth_ct_primary = 12'h320;
    gnd_supervise_only = 1'b0;
    gnd_block = 1'b0;
    gnd_trip_delay = 16'h0005;
    gnd_reset_mode = rst_instant;
    gnd_time_mult = 16'h0002;
    gnd_reset_delay = 16'h0006;
    cyc(20);
    arst_n = 1'b1;
    cyc(2);
    chk(unb_alarm | unb_trip | gnd_alarm | gnd_trip, 1'b0, "outputs after reset");
    // Ground pickup is 0.5 of the earth transformer primary, 400 units
    ground_current = 12'h190;
    cyc(3);
    chk(gnd_alarm, 1'b0, "ground pickup not strict");
    ground_current = 12'h191;
    cyc(2);
    chk(gnd_alarm, 1'b1, "ground pickup missed");
    wait_out(3, 40, n);
    chk_rng(n, 6, 14, "ground trip delay");
    earth_ct_primary = 12'h640;
    cyc(3);
    chk(gnd_alarm | gnd_trip, 1'b0, "pickup not scaled by earth primary");
    earth_ct_primary = 12'h320;
    cyc(2);
    wait_out(3, 40, n);
    chk_rng(n, 6, 14, "ground delay after instant reset");
    gnd_supervise_only = 1'b1;
    cyc(3);
    chk(gnd_trip, 1'b0, "trip under supervise only");
    chk(gnd_alarm, 1'b1, "alarm lost under supervise only");
    gnd_supervise_only = 1'b0;
    gnd_block = 1'b1;
    cyc(3);
    chk(gnd_trip, 1'b0, "trip while blocked");
    gnd_block = 1'b0;
    gnd_gap(rst_characteristic, 8, 1'b1);
    gnd_gap(rst_characteristic, 12, 1'b0);
    gnd_gap(rst_delayed, 8, 1'b0);
    gnd_gap(rst_delayed, 4, 1'b1);
    // Alarm falls first; a pickup with enable low must then stay unseen
    ground_current = 12'h000;
    cyc(2);
    ce = 1'b0;
    ground_current = 12'h191;
    cyc(4);
    chk(gnd_alarm, 1'b0, "state moved with enable low");
    ce = 1'b1;
    ground_current = 12'h000;
    $display("test ground done");
    // Phase A alone: both sequences are a third of it, threshold 480
    phase(1380, 0, 0, 0, 0, 0);
    cyc(4);
    chk(unb_alarm, 1'b0, "alarm below threshold");
    phase(1500, 0, 0, 0, 0, 0);
    cyc(3);
    chk(unb_alarm, 1'b1, "alarm above threshold");
    wait_out(1, 100, n);
    chk_rng(n, 36, 43, "fixed curve delay");
    rated_current = 12'h208;
    cyc(3);
    chk(unb_alarm | unb_trip, 1'b0, "threshold not scaled by rated");
    rated_current = 12'h1e0;
    ratio_enable = 1'b1;
    for (int p = 99; p <= 100; p++) begin
      unbalance_ratio_pickup = PCT_W'(p);
      cyc(3);
      chk(unb_alarm, (p == 99) ? 1'b1 : 1'b0, "ratio of single phase");
    end
    ratio_enable = 1'b0;
    phase(1000, 0, -500, -866, -500, 866);
    cyc(3);
    chk(unb_alarm, 1'b0, "balanced set seen unbalanced");
    phase_reversed = 1'b1;
    cyc(3);
    chk(unb_alarm, 1'b1, "reversed rotation ignored");
    phase_reversed = 1'b0;
    $display("test unbalance done");
    // Cold start needs 118 ticks; the fixed delay of 2 must not apply
    unb_curve = thermal_dependent_curve;
    unb_delay = 16'h0002;
    heat_run(4, 5'h00, 228, 246);
    heat_run(10, 5'h0a, 0, 20);
    // Halving leaves under max/100 after seven ticks; a kept residue trips early
    heat_run(7, 5'h01, 237, 239);
    $display("test thermal done");
    summarize();
  end
endmodule
`default_nettype wire
